// File: core/conv_start_bit_control.sv
// converter sequencer: registers, timing control, result and interrupt
module conv_start_bit_control
    import conv_start_bit_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic [AW-1:0]    reg_addr,
    input  wire logic [DW-1:0]    reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [DW-1:0]    reg_rdata,
    input  wire logic             standby,
    input  wire logic             cpu_wait,
    input  wire logic             comp_in,
    output logic                  conv_end_irq,
    output logic                  comparator_power_enable,
    output logic                  ref_current_en,
    output logic                  sample_en,
    output logic      [CH_W-1:0]  channel_sel,
    output logic      [RES_W-1:0] dac_code,
    output logic                  conv_busy
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    conv_start_bit_tim_if tif ();

    conv_start_bit_state_e     state_q;
    conv_start_bit_state_e     state_d;
    logic [BW-1:0]   conv_mode_reg_q;
    logic [BW-1:0]   channel_select_reg_q;
    logic [BW-1:0]   compare_mode_reg_q;
    logic [BW-1:0]   compare_threshold_reg_q;
    logic [DW-1:0]   conv_result_reg_q;
    logic [BW-1:0]   sts_q;
    logic [BW-1:0]   mask_q;
    logic [DW-1:0]   rdata_q;
    logic            irq_q;
    logic            sample_en_q;
    logic            busy_q;
    logic            comp_s1_q;
    logic            comp_s2_q;
    logic            comp_s3_q;
    logic            comp_q;
    logic [RES_W-1:0] sar_trial;
    logic [RES_W-1:0] sar_res;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire wr_mode   = reg_wr && (reg_addr == OFS_MODE);
    wire wr_chan   = reg_wr && (reg_addr == OFS_CHAN);
    wire wr_cmpm   = reg_wr && (reg_addr == OFS_CMPM);
    wire wr_thr    = reg_wr && (reg_addr == OFS_THR);
    wire wr_mask   = reg_wr && (reg_addr == OFS_MASK);
    wire rd_result = reg_rd && (reg_addr == OFS_RESULT);
    wire rd_sts    = reg_rd && (reg_addr == OFS_STS);
    wire wr_abort  = wr_mode || wr_chan || wr_cmpm || wr_thr;

    wire [BW-1:0] mode_d = wr_mode ? reg_wdata[BW-1:0] : conv_mode_reg_q;
    wire [BW-1:0] chan_d = wr_chan ? reg_wdata[BW-1:0] : channel_select_reg_q;
    wire [BW-1:0] cmpm_d = wr_cmpm ? reg_wdata[BW-1:0] : compare_mode_reg_q;
    wire [BW-1:0] thr_d  = wr_thr  ? reg_wdata[BW-1:0] : compare_threshold_reg_q;
    wire [BW-1:0] mask_d = wr_mask ? reg_wdata[BW-1:0] : mask_q;

    // ------------------------------------------------------------
    // sequencing conditions
    // ------------------------------------------------------------
    wire start_d   = mode_d[MODE_START_BIT];
    wire go        = start_d && tif.legal && !standby;
    wire delay_end = (state_q == ST_DELAY) && !cpu_wait && (tif.cnt == tif.delay_cyc - CNT_ONE);
    wire samp_end  = (state_q == ST_SAMPLE) && (tif.cnt == tif.samp_cyc - CNT_ONE);
    wire end_hit   = (state_q == ST_CONVERT) && (tif.cnt == tif.conv_cyc - tif.samp_cyc - CNT_ONE);
    wire done_ok   = end_hit && go && !wr_abort;
    wire early     = (state_q == ST_IDLE) || (state_q == ST_DELAY);

    wire [BW-1:0]  res_hi  = sar_res[RES_W-1:THR_LO];
    wire           cmp_hit = compare_mode_reg_q[CMP_COND_BIT] ? (res_hi <  compare_threshold_reg_q)
                                                              : (res_hi >= compare_threshold_reg_q);
    wire           irq_set = done_ok && (!compare_mode_reg_q[CMP_EN_BIT] || cmp_hit);
    wire [DW-1:0]  new_result = DW'(sar_res) << RES_SHIFT;
    wire [DW-1:0]  result_d   = done_ok ? new_result : conv_result_reg_q;

    wire [BW-1:0]  sts_set = irq_set ? STS_END_MASK : '0;
    wire [BW-1:0]  sts_clr = rd_sts ? sts_q : '0;
    wire [BW-1:0]  sts_d   = (sts_q & ~sts_clr) | sts_set;

    always_comb begin
        state_d = state_q;
        if (!go) begin
            state_d = ST_IDLE;
        end else if (wr_abort) begin
            state_d = early ? ST_DELAY : ST_SAMPLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    state_d = ST_DELAY;
                end
                ST_DELAY: begin
                    if (delay_end) begin
                        state_d = ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    if (samp_end) begin
                        state_d = ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    if (end_hit) begin
                        state_d = ST_SAMPLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // timer and approximation
    // ------------------------------------------------------------
    assign tif.speed      = mode_d[MODE_SPD_HI:MODE_SPD_LO];
    assign tif.clr        = (state_d != state_q) || wr_abort;
    assign tif.run        = ((state_q == ST_DELAY) && !cpu_wait) || (state_q == ST_SAMPLE) ||
                            (state_q == ST_CONVERT);
    assign tif.conv_phase = (state_q == ST_CONVERT);

    wire sar_start = (state_d == ST_SAMPLE) && tif.clr;

    conv_start_bit_timing u_timing (
        .clk_sys (clk_sys),
        .reset   (reset),
        .tif     (tif)
    );

    conv_start_bit_sar u_sar (
        .clk_sys (clk_sys),
        .reset   (reset),
        .start   (sar_start),
        .strobe  (tif.bit_strobe),
        .comp_hi (comp_q),
        .trial   (sar_trial),
        .result  (sar_res)
    );

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [DW-1:0] rd_state = DW'({tif.legal, sample_en_q, busy_q});
    wire [DW-1:0] rd_mux =
        (reg_addr == OFS_MODE)   ? DW'(conv_mode_reg_q)         :
        (reg_addr == OFS_CHAN)   ? DW'(channel_select_reg_q)    :
        (reg_addr == OFS_CMPM)   ? DW'(compare_mode_reg_q)      :
        (reg_addr == OFS_THR)    ? DW'(compare_threshold_reg_q) :
        (reg_addr == OFS_RESULT) ? conv_result_reg_q            :
        (reg_addr == OFS_STS)    ? DW'(sts_q)                   :
        (reg_addr == OFS_MASK)   ? DW'(mask_q)                  :
        (reg_addr == OFS_STATE)  ? rd_state                     : '0;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            conv_mode_reg_q         <= REG_RST;
            channel_select_reg_q    <= REG_RST;
            compare_mode_reg_q      <= REG_RST;
            compare_threshold_reg_q <= REG_RST;
            mask_q                  <= REG_RST;
            sts_q                   <= REG_RST;
        end else begin
            conv_mode_reg_q         <= mode_d;
            channel_select_reg_q    <= chan_d;
            compare_mode_reg_q      <= cmpm_d;
            compare_threshold_reg_q <= thr_d;
            mask_q                  <= mask_d;
            sts_q                   <= sts_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            conv_result_reg_q <= '0;
            rdata_q           <= '0;
        end else begin
            rdata_q           <= reg_rd ? rd_mux : '0;
            conv_result_reg_q <= result_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q     <= ST_IDLE;
            sample_en_q <= 1'b0;
            busy_q      <= 1'b0;
            irq_q       <= 1'b0;
        end else begin
            state_q     <= state_d;
            sample_en_q <= (state_d == ST_SAMPLE);
            busy_q      <= (state_d != ST_IDLE);
            irq_q       <= |(sts_d & mask_d);
        end
    end

    // comparator pin: three stages, accept when the last two agree
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            comp_s1_q <= 1'b0;
            comp_s2_q <= 1'b0;
            comp_s3_q <= 1'b0;
            comp_q    <= 1'b0;
        end else begin
            comp_s1_q <= comp_in;
            comp_s2_q <= comp_s1_q;
            comp_s3_q <= comp_s2_q;
            if (comp_s2_q == comp_s3_q) begin
                comp_q <= comp_s3_q;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata               = rdata_q;
    assign conv_end_irq            = irq_q;
    assign comparator_power_enable = conv_mode_reg_q[MODE_PWR_BIT];
    assign ref_current_en          = conv_mode_reg_q[MODE_START_BIT];
    assign sample_en               = sample_en_q;
    assign channel_sel             = channel_select_reg_q[CH_W-1:0];
    assign dac_code                = sar_trial;
    assign conv_busy               = busy_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_read_first: assert property (
        (rd_result && done_ok) |=> (reg_rdata == $past(conv_result_reg_q)) && (conv_result_reg_q == $past(new_result)))
        else $error("result read did not see the old value first");

    a_write_blocks_store: assert property (
        (end_hit && (wr_mode || wr_chan)) |=> $stable(conv_result_reg_q) &&
                                              (!sts_q[STS_END_BIT] || $past(sts_q[STS_END_BIT])))
        else $error("end-cycle write did not block the store");

    a_chan_keeps_flag: assert property (
        (wr_chan && sts_q[STS_END_BIT] && !rd_sts) |=> sts_q[STS_END_BIT])
        else $error("channel write cleared the end flag");

    a_conv_length: assert property (
        ((state_q == ST_CONVERT) && (state_d == ST_SAMPLE) && !wr_abort) |->
        (tif.cnt == tif.conv_cyc - tif.samp_cyc - CNT_ONE))
        else $error("conversion length wrong");

    a_sample_length: assert property (
        ((state_q == ST_SAMPLE) && (state_d == ST_CONVERT)) |-> (tif.cnt == tif.samp_cyc - CNT_ONE) ##1 !sample_en)
        else $error("sampling length wrong");

    a_delay_length: assert property (
        ((state_q == ST_DELAY) && (state_d == ST_SAMPLE) && !wr_abort) |->
        (tif.cnt == tif.delay_cyc - CNT_ONE) ##1 sample_en)
        else $error("start delay length wrong");

    a_wait_freezes: assert property (
        ((state_q == ST_DELAY) && cpu_wait && go && !wr_abort) |=> $stable(tif.cnt) && (state_q == ST_DELAY))
        else $error("start delay advanced during wait");

    a_standby_stops: assert property (
        standby |=> (state_q == ST_IDLE) && !sample_en && !conv_busy)
        else $error("conversion ran in standby");

    a_back_to_back: assert property (
        done_ok |=> (state_q == ST_SAMPLE) && (tif.cnt == '0) && sample_en)
        else $error("next conversion did not follow at once");

    a_abort_restart: assert property (
        (wr_abort && go && !early) |=> (state_q == ST_SAMPLE) && (tif.cnt == '0))
        else $error("write did not restart the conversion");

    a_flag_with_result: assert property (
        irq_set |=> sts_q[STS_END_BIT] && (conv_result_reg_q == $past(new_result)))
        else $error("end flag and result not loaded together");

    a_irq_level: assert property (
        conv_end_irq == |(sts_q & mask_q))
        else $error("interrupt output does not follow status and mask");

    a_result_kept: assert property (
        (wr_mode || wr_chan) |=> $stable(conv_result_reg_q))
        else $error("mode or channel write changed the result");

    a_illegal_idle: assert property (
        !tif.legal |=> !conv_busy)
        else $error("prohibited speed code started a conversion");

    a_idle_to_delay: assert property (
        ((state_q == ST_IDLE) && go) |=> (state_q == ST_DELAY) && !sample_en)
        else $error("start did not begin with the start delay");

    a_stop_idle: assert property (
        (wr_mode && !reg_wdata[MODE_START_BIT]) |=> !conv_busy && !ref_current_en)
        else $error("cleared start bit did not stop conversion");

    a_power_bit: assert property (
        wr_mode |=> (comparator_power_enable == $past(reg_wdata[MODE_PWR_BIT])))
        else $error("power enable does not follow mode bit 0");

    a_status_clear: assert property (
        (rd_sts && !irq_set) |=> !sts_q[STS_END_BIT])
        else $error("status read did not clear the end flag");

    a_rdata_idle: assert property (
        !reg_rd |=> (reg_rdata == '0))
        else $error("read data stood outside the read cycle");

    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    c_conv_done:    cover property (done_ok);
    c_abort_conv:   cover property ((state_q == ST_CONVERT) && wr_abort && go);
    c_read_collide: cover property (rd_result && done_ok);
    c_wait_delay:   cover property ((state_q == ST_DELAY) && cpu_wait ##1 (state_q == ST_DELAY));
    c_cmp_reject:   cover property (done_ok && !irq_set);

endmodule

// File: core/conv_start_bit_pkg.sv
// constants, tables and types shared by the converter sequencer files
package conv_start_bit_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DW    = 16;
    localparam int AW    = 4;
    localparam int BW    = 8;
    localparam int CW    = 9;
    localparam int RES_W = 10;
    localparam int CH_W  = 3;
    localparam int SPD_W = 3;
    localparam int NCODE = 8;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [AW-1:0] OFS_MODE   = 4'h0;
    localparam logic [AW-1:0] OFS_CHAN   = 4'h1;
    localparam logic [AW-1:0] OFS_CMPM   = 4'h2;
    localparam logic [AW-1:0] OFS_THR    = 4'h3;
    localparam logic [AW-1:0] OFS_RESULT = 4'h4;
    localparam logic [AW-1:0] OFS_STS    = 4'h5;
    localparam logic [AW-1:0] OFS_MASK   = 4'h6;
    localparam logic [AW-1:0] OFS_STATE  = 4'h7;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int MODE_START_BIT = 7;
    localparam int MODE_SPD_HI    = 5;
    localparam int MODE_SPD_LO    = 3;
    localparam int MODE_PWR_BIT   = 0;
    localparam int CMP_EN_BIT     = 7;
    localparam int CMP_COND_BIT   = 6;
    localparam int STS_END_BIT    = 0;
    localparam int RES_SHIFT      = 6;
    localparam int THR_LO         = RES_W - BW;
    localparam logic [BW-1:0]    STS_END_MASK = 8'h01;
    localparam logic [BW-1:0]    REG_RST      = 8'h00;
    localparam logic [RES_W-1:0] SAR_TOP      = 10'h200;
    localparam logic [CW-1:0]    CNT_ONE      = 9'h001;

    // ------------------------------------------------------------
    // timing per speed code, in x1 clock cycles (index = code)
    // ------------------------------------------------------------
    localparam logic [NCODE-1:0] LEGAL_MASK = 8'h77;
    localparam logic [CW-1:0] CONV_TAB [NCODE] =
        '{9'h120, 9'h0F0, 9'h0C0, 9'h000, 9'h090, 9'h078, 9'h060, 9'h000};
    localparam logic [CW-1:0] SAMP_TAB [NCODE] =
        '{9'h028, 9'h020, 9'h018, 9'h000, 9'h014, 9'h010, 9'h00C, 9'h000};
    localparam logic [CW-1:0] DLY_MIN_TAB [NCODE] =
        '{9'h020, 9'h01C, 9'h018, 9'h000, 9'h010, 9'h00E, 9'h00C, 9'h000};
    localparam logic [CW-1:0] DLY_MAX_TAB [NCODE] =
        '{9'h024, 9'h020, 9'h01C, 9'h000, 9'h012, 9'h010, 9'h00E, 9'h000};

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DELAY,
        ST_SAMPLE,
        ST_CONVERT
    } conv_start_bit_state_e;

endpackage

// File: core/conv_start_bit_sar.sv
// 10-bit successive approximation register
module conv_start_bit_sar
    import conv_start_bit_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic             start,
    input  wire logic             strobe,
    input  wire logic             comp_hi,
    output logic [RES_W-1:0]      trial,
    output logic [RES_W-1:0]      result
);

    logic [RES_W-1:0] trial_q;
    logic [RES_W-1:0] res_q;
    logic [RES_W-1:0] bit_q;
    wire  [RES_W-1:0] keep;
    wire              take;

    // ------------------------------------------------------------
    // bit decision, msb first
    // ------------------------------------------------------------
    assign keep   = comp_hi ? trial_q : (trial_q & ~bit_q);
    assign take   = strobe && (bit_q != '0);
    assign trial  = trial_q;
    assign result = res_q;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            trial_q <= '0;
            res_q   <= '0;
            bit_q   <= '0;
        end else if (start) begin
            trial_q <= SAR_TOP;
            res_q   <= '0;
            bit_q   <= SAR_TOP;
        end else if (take) begin
            res_q   <= keep;
            bit_q   <= bit_q >> 1;
            trial_q <= keep | (bit_q >> 1);
        end
    end

    a_sar_msb_first: assert property (@(posedge clk_sys) disable iff (reset)
        start |=> (trial == SAR_TOP) && (bit_q == SAR_TOP))
        else $error("approximation did not start at the top bit");

endmodule

// File: core/conv_start_bit_tim_if.sv
// link between the sequencer and its cycle timer
interface conv_start_bit_tim_if;
    import conv_start_bit_pkg::*;
    logic [SPD_W-1:0] speed;
    logic             clr;
    logic             run;
    logic             conv_phase;
    logic [CW-1:0]    cnt;
    logic             bit_strobe;
    logic [CW-1:0]    conv_cyc;
    logic [CW-1:0]    samp_cyc;
    logic [CW-1:0]    delay_cyc;
    logic             legal;

    modport ctl (output speed, clr, run, conv_phase,
                 input  cnt, bit_strobe, conv_cyc, samp_cyc, delay_cyc, legal);
    modport tim (input  speed, clr, run, conv_phase,
                 output cnt, bit_strobe, conv_cyc, samp_cyc, delay_cyc, legal);
endinterface

// File: core/conv_start_bit_timing.sv
// cycle timer and speed-code lookup of the converter sequencer
module conv_start_bit_timing
    import conv_start_bit_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset,
    conv_start_bit_tim_if.tim   tif
);

    // ------------------------------------------------------------
    // lookup
    // ------------------------------------------------------------
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] step_q;
    wire  [CW-1:0] step_cyc;
    wire           step_end;

    assign tif.conv_cyc  = CONV_TAB[tif.speed];
    assign tif.samp_cyc  = SAMP_TAB[tif.speed];
    assign tif.delay_cyc = DLY_MIN_TAB[tif.speed];
    assign tif.legal     = LEGAL_MASK[tif.speed];
    assign step_cyc      = CW'((CONV_TAB[tif.speed] - SAMP_TAB[tif.speed]) / RES_W);
    assign step_end      = tif.conv_phase && (step_q == step_cyc - CNT_ONE);
    assign tif.bit_strobe = step_end;
    assign tif.cnt       = cnt_q;

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset || tif.clr) begin
            cnt_q <= '0;
        end else if (tif.run) begin
            cnt_q <= cnt_q + CNT_ONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || tif.clr || !tif.conv_phase || step_end) begin
            step_q <= '0;
        end else begin
            step_q <= step_q + CNT_ONE;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_counter_clear: assert property (@(posedge clk_sys) disable iff (reset)
        tif.clr |=> (tif.cnt == '0))
        else $error("cycle counter not cleared on restart");

    a_counter_runs: assert property (@(posedge clk_sys) disable iff (reset)
        (tif.run && !tif.clr) |=> (tif.cnt == $past(tif.cnt) + CNT_ONE))
        else $error("cycle counter did not advance");

endmodule

// File: test/conv_start_bit_control_tb_top.sv
// self-checking bench of the converter sequencer
module conv_start_bit_control_tb_top
    import conv_start_bit_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [SPD_W-1:0] code; int dly; int samp; int conv;} conv_start_bit_row_s;
    logic             clk_sys, reset, reg_wr, reg_rd, standby, cpu_wait, comp_in;
    logic [AW-1:0]    reg_addr;
    logic [DW-1:0]    reg_wdata, reg_rdata, v;
    logic             conv_end_irq, comparator_power_enable, ref_current_en, sample_en, conv_busy;
    logic [CH_W-1:0]  channel_sel;
    logic [RES_W-1:0] dac_code;
    int               err_count = 0, compares = 0, t = 0;
    conv_start_bit_row_s        rows [6] = '{'{3'h0, 32, 40, 288}, '{3'h1, 28, 32, 240}, '{3'h2, 24, 24, 192},
                                   '{3'h4, 16, 20, 144}, '{3'h5, 14, 16, 120}, '{3'h6, 12, 12, 96}};
    conv_start_bit_control DUT (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .standby(standby), .cpu_wait(cpu_wait),
        .comp_in(comp_in), .conv_end_irq(conv_end_irq), .comparator_power_enable(comparator_power_enable),
        .ref_current_en(ref_current_en), .sample_en(sample_en), .channel_sel(channel_sel),
        .dac_code(dac_code), .conv_busy(conv_busy));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [DW-1:0] got, input logic [DW-1:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic step;
        @(posedge clk_sys);
        #1;
        t++;
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
        t = 1;
    endtask
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        t += 2;
    endtask
    task automatic wfor(input bit sel, input logic lv);
        int n;
        n = 0;
        while (((sel ? conv_end_irq : sample_en) !== lv) && n < 600) begin
            step;
            n++;
        end
        if (n >= 600) chk("wait", 16'h0001, 16'h0000);
    endtask
    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        #1000000;
        err_count++;
        end_sim;
    end
    initial begin
        reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0;
        standby = 1'b0; cpu_wait = 1'b0; comp_in = 1'b1;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        wr(OFS_MODE, 16'h00B1);
        repeat (110) step;
        chk("irq_masked", 16'(conv_end_irq), 16'h0000);
        rd(OFS_STS, v); chk("sts_masked", v, 16'h0001);
        wr(OFS_MASK, 16'h0001);
        foreach (rows[i]) begin
            wr(OFS_MODE, 16'h0001); rd(OFS_STS, v);
            wr(OFS_MODE, 16'h0081 | (16'(rows[i].code) << MODE_SPD_LO));
            chk("pwr", 16'(comparator_power_enable), 16'h0001);
            chk("ref", 16'(ref_current_en), 16'h0001);
            wfor(0, 1); chk("dly", 16'(t), 16'(1 + rows[i].dly));
            chk("dac", 16'(dac_code), 16'h0200);
            wfor(0, 0); chk("samp", 16'(t), 16'(1 + rows[i].dly + rows[i].samp));
            wfor(1, 1); chk("conv", 16'(t), 16'(1 + rows[i].dly + rows[i].conv));
            chk("b2b", 16'(sample_en), 16'h0001);
            rd(OFS_RESULT, v); chk("res", v, 16'hFFC0);
            rd(OFS_STS, v); chk("sts", v, 16'h0001); step; chk("irq_clr", 16'(conv_end_irq), 16'h0000);
            $display("row %0d done", i);
        end
        wr(OFS_MODE, 16'h0001); @(posedge clk_sys); cpu_wait <= 1'b1;
        wr(OFS_MODE, 16'h00B1); repeat (5) @(posedge clk_sys); cpu_wait <= 1'b0; #1; t = 6;
        wfor(0, 1); chk("wait_dly", 16'(t), 16'h0012);
        wfor(1, 1); wr(OFS_CHAN, 16'h0005);
        chk("chan", 16'(channel_sel), 16'h0005);
        chk("irq_kept", 16'(conv_end_irq), 16'h0001);
        chk("abort", 16'(sample_en), 16'h0001);
        rd(OFS_STS, v); chk("sts_kept", v, 16'h0001);
        wfor(1, 1); chk("restart", 16'(t), 16'h0061);
        $display("wait and abort done");
        rd(OFS_STS, v); while (t < 190) step;
        @(posedge clk_sys); comp_in <= 1'b0;
        wr(OFS_MODE, 16'h00B1); chk("no_flag", 16'(conv_end_irq), 16'h0000);
        step; chk("no_flag", 16'(conv_end_irq), 16'h0000);
        rd(OFS_RESULT, v); chk("no_store", v, 16'hFFC0);
        wfor(1, 1); rd(OFS_RESULT, v); chk("res_zero", v, 16'h0000);
        @(posedge clk_sys); comp_in <= 1'b1; #1; t++;
        while (t < 191) step;
        rd(OFS_RESULT, v); chk("rd_first", v, 16'h0000);
        rd(OFS_RESULT, v); chk("rd_then", v, 16'hFFC0);
        $display("conflicts done");
        rd(OFS_STS, v); wr(OFS_THR, 16'h00FF); wr(OFS_CMPM, 16'h00C0); repeat (100) step;
        chk("cmp_none", 16'(conv_end_irq), 16'h0000);
        wr(OFS_CMPM, 16'h0080); wfor(1, 1); chk("cmp_restart", 16'(t), 16'h0061);
        $display("compare done");
        @(posedge clk_sys); standby <= 1'b1; repeat (3) step;
        chk("stby", 16'(conv_busy), 16'h0000);
        @(posedge clk_sys); standby <= 1'b0;
        wr(OFS_MODE, 16'h0031); chk("ref_off", 16'(ref_current_en), 16'h0000);
        wr(OFS_MODE, 16'h00B9); step; chk("illegal", 16'(conv_busy), 16'h0000);
        rd(OFS_STATE, v); chk("state_idle", v, 16'h0000);
        wr(OFS_MODE, 16'h00B1); repeat (20) step;
        rd(OFS_STATE, v); chk("state_run", v, 16'h0007);
        @(posedge clk_sys); reset <= 1'b1; repeat (2) @(posedge clk_sys); reset <= 1'b0; #1;
        chk("rst_busy", 16'(conv_busy), 16'h0000);
        rd(OFS_MODE, v); chk("rst_mode", v, 16'h0000);
        rd(4'hF, v); chk("unmapped", v, 16'h0000);
        $display("standby and reset done");
        end_sim;
    end
endmodule
